// *** rtl/acp_pkg.sv ***
// constants and types for the paired converter control block
// assumes a 32-bit axi4-lite slave port with 8-bit byte addresses
package acp_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STAT     = 8'h04;
  localparam logic [7:0] OFF_BASE     = 8'h08;
  localparam logic [7:0] OFF_PAIR0    = 8'h0C;
  localparam logic [7:0] OFF_PAIR2    = 8'h14;
  localparam logic [7:0] OFF_RES      = 8'h40;
  localparam logic [7:0] OFF_RES_LAST = 8'h6C;

  // ****************************************
  // control fields
  // ****************************************
  localparam int         CTRL_ON    = 15;
  localparam int         CTRL_SIDL  = 13;
  localparam int         CTRL_GSW   = 10;
  localparam int         CTRL_RESULT_FORMAT  = 8;
  localparam int         CTRL_EIE   = 7;
  localparam int         CTRL_ORDER = 6;
  localparam int         CTRL_SEQ   = 5;
  localparam logic [15:0] CTRL_WMASK = 16'hA5E7;
  localparam logic [15:0] CTRL_RESET = 16'h0003;

  // ****************************************
  // sizes, trigger codes, timing
  // ****************************************
  localparam int          NPAIR       = 6;
  localparam int          NIN         = 12;
  localparam int          RES_W       = 10;
  localparam logic [4:0]  TRG_NONE    = 5'h00;
  localparam logic [4:0]  TRG_SW      = 5'h01;
  localparam logic [4:0]  TRG_GLOBAL  = 5'h02;
  localparam logic [11:0] SHARED_MASK = 12'h0500;
  localparam logic [3:0]  CONV_TICKS  = 4'hC;
  localparam logic [4:0]  DIV_PLL_MIN = 5'h08;
  localparam logic [4:0]  DIV_OFFSET  = 5'h04;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic       pair_irq_enable;
    logic       pair_pending;
    logic       pair_soft_trigger;
    logic [4:0] src;
  } acp_pair_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_FIRST  = 2'b01,
    ST_SECOND = 2'b10
  } acp_state_t;

endpackage

// *** rtl/acp_ctrl.sv ***
// paired converter control: registers, triggers, sequencing, result buffer
// assumes an axi4-lite master, sar data valid at end of each conversion
// Functional notes
// - twelve inputs, converted as pairs of results
// - each dedicated hold triggered independently
// - no conversions unless pll clock selected
// - module on bit runs the converter
// - stop in idle halts during idle
// - global trigger not self clearing, edge starts
// - format bit chooses left or right justify
// - early irq after first conversion
// - order bit picks odd or even first
// - sequential sample timing of shared hold
// - shared hold samples now or at next pair conversion start
// - divider codes give divide 18 down to 4
// - codes 001 and 000 act as divide 8
// - ready flag set, cleared by writing zero
// - base holds bits 15-1, bit 0 zero
// - base read adds encoded ready index
// - pair 0 highest priority, pair 5 lowest
// - index shifted left two before adding
// - lowest numbered pending pair converts first
// - pending set on trigger, cleared on completion
// - global trigger only for global source code
// - pair irq only when its enable set
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module acp_ctrl (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // system state and trigger sources
  input  wire logic        pll_sel_i,
  input  wire logic        idle_mode_i,
  input  wire logic [31:0] ext_trig_i,
  // analog side
  input  wire logic [9:0]  sar_data_i,
  output logic [11:0]      ded_sample_o,
  output logic             shared_sample_o,
  output logic [3:0]       sar_chan_o,
  output logic             sar_busy_o,
  // pair events
  output logic [5:0]       pair_irq_o
);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d,
                                          input logic [1:0] strb);
    merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
  endfunction

  // lowest set bit wins, returns {found, index}
  function automatic logic [3:0] lowest6(input logic [5:0] v);
    lowest6 = 4'h0;
    for (int i = acp_pkg::NPAIR - 1; i >= 0; i--) begin
      if (v[i]) begin
        lowest6 = {1'b1, 3'(i)};
      end
    end
  endfunction

  function automatic logic [4:0] div_len(input logic [2:0] code, input logic pll);
    if (pll && code < 3'h2) begin
      div_len = acp_pkg::DIV_PLL_MIN;
    end else begin
      div_len = 5'({code, 1'b0}) + acp_pkg::DIV_OFFSET;
    end
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'h0) &&
              (a <= acp_pkg::OFF_PAIR2 ||
               (a >= acp_pkg::OFF_RES && a <= acp_pkg::OFF_RES_LAST));
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [15:0]          ctrl;
  logic [5:0]           ready;
  logic [15:1]          base;
  acp_pkg::acp_pair_t   pair [acp_pkg::NPAIR];
  logic [9:0]           res_mem [acp_pkg::NIN];
  acp_pkg::acp_state_t  state;
  logic [2:0]           cur_pair;
  logic [4:0]           div_cnt;
  logic [3:0]           tick_cnt;
  logic                 gsw_q;
  logic                 shared_defer;
  logic                 aw_hold;
  logic                 w_hold;
  logic [7:0]           waddr;
  logic [15:0]          wdata;
  logic [1:0]           wstrb;
  logic [7:0]           phase_cyc;

  logic                 run;
  logic                 tick;
  logic                 phase_end;
  logic                 wr_go;
  logic [5:0]           pair_pending_vec;
  logic [5:0]           hit;
  logic [3:0]           sel;
  logic [3:0]           rdy_enc;
  logic                 enter_first;
  logic                 enter_second;
  logic                 first_end;
  logic                 second_end;
  logic                 shared_busy;
  logic                 shared_trig;
  logic [31:0]          rd_word;

  assign run = ctrl[acp_pkg::CTRL_ON] && pll_sel_i &&
               !(ctrl[acp_pkg::CTRL_SIDL] && idle_mode_i);
  assign tick         = div_cnt == div_len(ctrl[2:0], pll_sel_i) - 5'h01;
  assign phase_end    = state != acp_pkg::ST_IDLE && tick &&
                        tick_cnt == acp_pkg::CONV_TICKS - 4'h1;
  assign wr_go        = aw_hold && w_hold && !s_axi_bvalid_o;
  assign sel          = lowest6(pair_pending_vec);
  assign rdy_enc      = lowest6(ready);
  assign enter_first  = run && state == acp_pkg::ST_IDLE && sel[3];
  assign first_end    = run && state == acp_pkg::ST_FIRST && phase_end;
  assign second_end   = run && state == acp_pkg::ST_SECOND && phase_end;
  assign enter_second = first_end;
  assign shared_busy  = state != acp_pkg::ST_IDLE && acp_pkg::SHARED_MASK[{cur_pair, 1'b0}];

  // ****************************************
  // per pair triggers and controls
  // ****************************************
  logic [5:0] shared_hit;
  assign shared_trig = |shared_hit;

  genvar p;
  generate
    for (p = 0; p < acp_pkg::NPAIR; p++) begin : g_pair
      localparam logic [7:0] PADDR = acp_pkg::OFF_PAIR0 + 8'(4 * (p / 2));
      logic        raw;
      logic [7:0]  wr_half;
      logic [15:0] wr_word;
      assign pair_pending_vec[p]   = pair[p].pair_pending;
      assign shared_hit[p] = hit[p] && acp_pkg::SHARED_MASK[2*p];
      assign wr_word = merge16({pair[(p/2)*2+1], pair[(p/2)*2]}, wdata, wstrb);
      assign wr_half = wr_word[8*(p%2) +: 8];
      always_comb begin
        unique case (pair[p].src)
          acp_pkg::TRG_NONE:   raw = 1'b0;
          acp_pkg::TRG_SW:     raw = pair[p].pair_soft_trigger;
          acp_pkg::TRG_GLOBAL: raw = ctrl[acp_pkg::CTRL_GSW] && !gsw_q;
          default:             raw = ext_trig_i[pair[p].src];
        endcase
      end
      assign hit[p] = run && raw;

      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          pair[p] <= '0;
        end else begin
          if (wr_go && waddr == PADDR) begin
            pair[p].pair_irq_enable <= wr_half[7];
            pair[p].src   <= wr_half[4:0];
          end
          if (hit[p]) begin
            pair[p].pair_pending  <= 1'b1;
            pair[p].pair_soft_trigger <= 1'b0;
          end else begin
            if (second_end && cur_pair == 3'(p)) begin
              pair[p].pair_pending <= 1'b0;
            end
            if (wr_go && waddr == PADDR) begin
              pair[p].pair_soft_trigger <= wr_half[5];
            end
          end
        end
      end

      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          ded_sample_o[2*p+1 -: 2] <= 2'h0;
          pair_irq_o[p]            <= 1'b0;
        end else begin
          ded_sample_o[2*p]   <= hit[p] && !acp_pkg::SHARED_MASK[2*p];
          ded_sample_o[2*p+1] <= hit[p] && !acp_pkg::SHARED_MASK[2*p+1];
          pair_irq_o[p] <= pair[p].pair_irq_enable && cur_pair == 3'(p) &&
                           ((first_end && ctrl[acp_pkg::CTRL_EIE]) ||
                            (second_end && !ctrl[acp_pkg::CTRL_EIE]));
        end
      end
    end
  endgenerate

  // ****************************************
  // control, status and base registers
  // ****************************************
  logic [15:0] stat_wr;
  logic [15:0] base_wr;
  assign stat_wr = merge16({10'h000, ready}, wdata, wstrb);
  assign base_wr = merge16({base, 1'b0}, wdata, wstrb);

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl  <= acp_pkg::CTRL_RESET;
      base  <= '0;
      gsw_q <= 1'b0;
    end else begin
      gsw_q <= ctrl[acp_pkg::CTRL_GSW];
      if (wr_go && waddr == acp_pkg::OFF_CTRL) begin
        ctrl <= merge16(ctrl, wdata, wstrb) & acp_pkg::CTRL_WMASK;
      end
      if (wr_go && waddr == acp_pkg::OFF_BASE) begin
        base <= base_wr[15:1];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ready <= '0;
    end else begin
      // set wins over a clear in the same cycle
      ready <= ((wr_go && waddr == acp_pkg::OFF_STAT) ? (ready & stat_wr[5:0]) : ready)
               | (second_end ? 6'(1) << cur_pair : 6'h00);
    end
  end

  // ****************************************
  // conversion sequencer
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state      <= acp_pkg::ST_IDLE;
      cur_pair   <= 3'h0;
      sar_chan_o <= 4'h0;
      sar_busy_o <= 1'b0;
    end else if (!run) begin
      state      <= acp_pkg::ST_IDLE;
      sar_busy_o <= 1'b0;
    end else begin
      unique case (state)
        acp_pkg::ST_IDLE: begin
          if (enter_first) begin
            state      <= acp_pkg::ST_FIRST;
            cur_pair   <= sel[2:0];
            sar_chan_o <= {sel[2:0], ctrl[acp_pkg::CTRL_ORDER]};
            sar_busy_o <= 1'b1;
          end
        end
        acp_pkg::ST_FIRST: begin
          if (phase_end) begin
            state      <= acp_pkg::ST_SECOND;
            sar_chan_o <= {cur_pair, !ctrl[acp_pkg::CTRL_ORDER]};
          end
        end
        acp_pkg::ST_SECOND: begin
          if (phase_end) begin
            state      <= acp_pkg::ST_IDLE;
            sar_busy_o <= 1'b0;
          end
        end
        default: begin
          state      <= acp_pkg::ST_IDLE;
          sar_busy_o <= 1'b0;
        end
      endcase
    end
  end

  // conversion clock divider and bit tick counter
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_cnt   <= 5'h00;
      tick_cnt  <= 4'h0;
      phase_cyc <= 8'h00;
    end else if (!run || state == acp_pkg::ST_IDLE || phase_end) begin
      div_cnt   <= 5'h00;
      tick_cnt  <= 4'h0;
      phase_cyc <= 8'h00;
    end else begin
      div_cnt   <= tick ? 5'h00 : div_cnt + 5'h01;
      tick_cnt  <= tick ? tick_cnt + 4'h1 : tick_cnt;
      phase_cyc <= phase_cyc + 8'h01;
    end
  end

  // result buffer, raw codes
  always_ff @(posedge sys_clk_i) begin
    if (first_end || second_end) begin
      res_mem[sar_chan_o] <= sar_data_i;
    end
  end

  // ****************************************
  // shared sample and hold
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shared_sample_o <= 1'b0;
      shared_defer    <= 1'b0;
    end else if (ctrl[acp_pkg::CTRL_SEQ]) begin
      shared_defer    <= 1'b0;
      shared_sample_o <= ctrl[acp_pkg::CTRL_ORDER]
                         ? enter_first && acp_pkg::SHARED_MASK[{sel[2:0], 1'b0}]
                         : enter_second && acp_pkg::SHARED_MASK[{cur_pair, 1'b0}];
    end else begin
      shared_sample_o <= (shared_trig && !shared_busy) || (shared_defer && enter_first);
      shared_defer    <= (shared_trig && shared_busy) || (shared_defer && !enter_first);
    end
  end

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_hold         <= 1'b0;
      w_hold          <= 1'b0;
      waddr           <= 8'h00;
      wdata           <= 16'h0000;
      wstrb           <= 2'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= acp_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_hold         <= 1'b1;
        waddr           <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_hold         <= 1'b1;
        wdata          <= s_axi_wdata_i[15:0];
        wstrb          <= s_axi_wstrb_i[1:0];
        s_axi_wready_o <= 1'b0;
      end
      if (wr_go) begin
        aw_hold        <= 1'b0;
        w_hold         <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= addr_ok(waddr) ? acp_pkg::RESP_OKAY : acp_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  always_comb begin
    logic [9:0] r;
    r       = res_mem[4'((s_axi_araddr_i - acp_pkg::OFF_RES) >> 2)];
    rd_word = 32'h0000_0000;
    if (s_axi_araddr_i == acp_pkg::OFF_CTRL) begin
      rd_word[15:0] = ctrl;
    end else if (s_axi_araddr_i == acp_pkg::OFF_STAT) begin
      rd_word[5:0] = ready;
    end else if (s_axi_araddr_i == acp_pkg::OFF_BASE) begin
      rd_word[15:0] = {base, 1'b0} + {11'h000, rdy_enc[2:0], 2'h0};
    end else if (s_axi_araddr_i <= acp_pkg::OFF_PAIR2) begin
      for (int j = 0; j < 3; j++) begin
        if (s_axi_araddr_i == acp_pkg::OFF_PAIR0 + 8'(4 * j)) begin
          rd_word[15:0] = {pair[2*j+1], pair[2*j]};
        end
      end
    end else if (ctrl[acp_pkg::CTRL_RESULT_FORMAT]) begin
      rd_word[15:0] = {r, 6'h00};
    end else begin
      rd_word[15:0] = {6'h00, r};
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= acp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= addr_ok(s_axi_araddr_i) ? rd_word : 32'h0000_0000;
      s_axi_rresp_o   <= addr_ok(s_axi_araddr_i) ? acp_pkg::RESP_OKAY : acp_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o  <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_first_done;
    state == acp_pkg::ST_FIRST && phase_end && run;
  endsequence
  sequence s_pair_done;
    state == acp_pkg::ST_SECOND && phase_end && run;
  endsequence

  a_pll_gate: assert property (!pll_sel_i |=> state == acp_pkg::ST_IDLE && !sar_busy_o)
    else $error("conversion active without pll clock");
  a_module_off: assert property (!ctrl[acp_pkg::CTRL_ON] |=> state == acp_pkg::ST_IDLE)
    else $error("conversion active while module off");
  a_idle_stop: assert property (ctrl[acp_pkg::CTRL_SIDL] && idle_mode_i
                                |=> state == acp_pkg::ST_IDLE)
    else $error("conversion active in idle with stop set");
  a_global_edge: assert property ($rose(ctrl[acp_pkg::CTRL_GSW]) && run &&
                                  pair[0].src == acp_pkg::TRG_GLOBAL |=> pair[0].pair_pending)
    else $error("global trigger did not set pending");
  a_order_chan: assert property (state == acp_pkg::ST_FIRST |->
                                 sar_chan_o[0] == ctrl[acp_pkg::CTRL_ORDER])
    else $error("first channel against order bit");
  a_phase_len: assert property (phase_end && state != acp_pkg::ST_IDLE |->
                                phase_cyc == 8'(acp_pkg::CONV_TICKS * div_len(ctrl[2:0], 1'b1)) - 8'h01)
    else $error("conversion phase length wrong");
  a_ready_set: assert property (s_pair_done |=> ready[$past(cur_pair)])
    else $error("ready flag not set after pair");
  a_ready_hold: assert property (ready[0] && !(wr_go && waddr == acp_pkg::OFF_STAT)
                                 |=> ready[0])
    else $error("ready flag lost without clear");
  a_early_irq: assert property (s_first_done ##0 ctrl[acp_pkg::CTRL_EIE] && pair[cur_pair].pair_irq_enable
                                |=> pair_irq_o[$past(cur_pair)])
    else $error("early interrupt missing");
  a_irq_gate: assert property (pair_irq_o[0] |-> $past(pair[0].pair_irq_enable))
    else $error("interrupt raised while disabled");
  a_lowest_first: assert property (enter_first && pair[0].pair_pending |=> cur_pair == 3'h0)
    else $error("lowest pending pair not chosen");
  a_base_read: assert property (s_axi_arvalid_i && s_axi_arready_o &&
                                s_axi_araddr_i == acp_pkg::OFF_BASE && (ready[0] || ready == 6'h00)
                                |=> s_axi_rvalid_o && s_axi_rdata_o[15:0] == {$past(base), 1'b0})
    else $error("base read value wrong");

endmodule

// *** dv/acp_far_model.sv ***
// far side model: converter result source for the control block
// assumes channel select and busy come from the control block
`timescale 1ns/100ps
module acp_far_model (
  // clock and converter side
  input  wire logic       sys_clk_i,
  input  wire logic [3:0] sar_chan_i,
  input  wire logic       sar_busy_i,
  // result
  output logic [9:0]      sar_data_o
);
  // ****************************************
  // result per channel, junk value when idle that stays at zero
  // ****************************************
  logic [9:0] junk = 10'h000;
  always @(posedge sys_clk_i) begin
    junk <= ~junk + 10'h001;
  end
  assign sar_data_o = sar_busy_i ? {sar_chan_i, 6'h15} : junk;
endmodule

// *** dv/tb_top.sv ***
// testbench for the paired converter control block
// assumes the axi4-lite slave and far side model described beside it
`timescale 1ns/100ps
module tb_top;
  // ****************************************
  // signals
  // ****************************************
  typedef struct packed {
    logic [7:0]  a;
    logic        w;
    logic [15:0] d;
    logic [15:0] q;
    logic [1:0]  r;
  } acp_row_t;
  logic sys_clk_i = 1'b0, resetn_i = 1'b0, pll_sel_i = 1'b1, idle_mode_i = 1'b0;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_arvalid_i = 1'b0;
  logic s_axi_bready_i = 1'b1, s_axi_rready_i = 1'b1;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0000_0000, ext_trig_i = 32'h0000_0000;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic shared_sample_o, sar_busy_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, br, rr;
  logic [31:0] s_axi_rdata_o;
  logic [11:0] ded_sample_o;
  logic [3:0] sar_chan_o, chq[$];
  logic [5:0] pair_irq_o;
  logic [9:0] sar_data_i;
  logic [15:0] rdv;
  logic busy_q = 1'b0, irq_busy = 1'b0;
  logic [7:0] sh_n = 8'h00;
  logic [3:0] sh_chan = 4'h0;
  logic [11:0] ded_seen = 12'h000;
  int num_errors = 0, n_tests = 0, cyc = 0, blen = 0, irq_n = 0, l7, l0, l1, n;
  logic [3:0] ins[4] = '{4'h0, 4'h1, 4'h8, 4'h9};
  acp_row_t rows[9] = '{
    '{acp_pkg::OFF_CTRL, 1'b0, 16'h0000, 16'h0003, 2'h0},
    '{acp_pkg::OFF_STAT, 1'b0, 16'h0000, 16'h0000, 2'h0},
    '{acp_pkg::OFF_BASE, 1'b0, 16'h0000, 16'h0000, 2'h0},
    '{acp_pkg::OFF_CTRL, 1'b1, 16'hFFFF, 16'hA5E7, 2'h0},
    '{acp_pkg::OFF_CTRL, 1'b1, 16'h0003, 16'h0003, 2'h0},
    '{acp_pkg::OFF_BASE, 1'b1, 16'hFFFF, 16'hFFFE, 2'h0},
    '{acp_pkg::OFF_STAT, 1'b1, 16'h003F, 16'h0000, 2'h0},
    '{8'h3C, 1'b1, 16'h1234, 16'h0000, 2'h2},
    '{8'h02, 1'b1, 16'h1234, 16'h0000, 2'h2}};

  acp_ctrl dut (.*);
  acp_far_model far (
    .sys_clk_i  (sys_clk_i),
    .sar_chan_i (sar_chan_o),
    .sar_busy_i (sar_busy_o),
    .sar_data_o (sar_data_i)
  );

  always #25 sys_clk_i = ~sys_clk_i;

  // ****************************************
  // monitor and watchdog
  // ****************************************
  always @(negedge sys_clk_i) begin
    if (sar_busy_o === 1'b1 && !busy_q) chq.push_back(sar_chan_o);
    if (sar_busy_o === 1'b1) blen++;
    if (|pair_irq_o) begin
      irq_n++;
      irq_busy = sar_busy_o;
    end
    ded_seen |= ded_sample_o;
    if (shared_sample_o === 1'b1) begin
      sh_n++;
      sh_chan = sar_chan_o;
    end
    busy_q = (sar_busy_o === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic conclude();
    if (num_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic ah, wh, bh;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {16'h0000, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge sys_clk_i);
      ah = s_axi_awvalid_i & s_axi_awready_o;
      wh = s_axi_wvalid_i & s_axi_wready_o;
      bh = s_axi_bvalid_o === 1'b1;
      br = s_axi_bresp_o;
      @(posedge sys_clk_i);
      if (ah) s_axi_awvalid_i <= 1'b0;
      if (wh) s_axi_wvalid_i <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic ah, rh;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge sys_clk_i);
      ah = s_axi_arvalid_i & s_axi_arready_o;
      rh = s_axi_rvalid_o === 1'b1;
      rdv = s_axi_rdata_o[15:0];
      rr = s_axi_rresp_o;
      @(posedge sys_clk_i);
      if (ah) s_axi_arvalid_i <= 1'b0;
    end
  endtask

  task automatic conv(input logic [15:0] c, input logic [7:0] p, output int len);
    wr(acp_pkg::OFF_CTRL, c & 16'h7FFF);
    wr(acp_pkg::OFF_CTRL, c);
    blen = 0;
    wr(acp_pkg::OFF_PAIR0, {8'h00, p});
    while (blen == 0 || sar_busy_o !== 1'b0) @(posedge sys_clk_i);
    repeat (4) @(posedge sys_clk_i);
    len = blen;
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    @(posedge sys_clk_i);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      if (rows[i].w) chk("bresp", {14'h0000, rows[i].r}, {14'h0000, br});
      rd(rows[i].a);
      chk("rresp", {14'h0000, rows[i].r}, {14'h0000, rr});
      chk("reg", rows[i].q, rdv);
    end
    wr(acp_pkg::OFF_BASE, 16'h0100);
    wr(acp_pkg::OFF_PAIR0, 16'h0082);
    wr(acp_pkg::OFF_PAIR2, 16'h0082);
    wr(acp_pkg::OFF_CTRL, 16'h8000);
    wr(acp_pkg::OFF_CTRL, 16'h8400);
    while (irq_n < 2) @(posedge sys_clk_i);
    repeat (4) @(posedge sys_clk_i);
    chk("order", 16'h0008, {8'h00, chq[0], chq[1]});
    rd(acp_pkg::OFF_CTRL);
    chk("ctrl", 16'h8400, rdv);
    rd(acp_pkg::OFF_STAT);
    chk("stat", 16'h0011, rdv);
    rd(acp_pkg::OFF_BASE);
    chk("base", 16'h0100, rdv);
    wr(acp_pkg::OFF_STAT, 16'h003E);
    rd(acp_pkg::OFF_BASE);
    chk("base", 16'h0110, rdv);
    for (int f = 0; f < 2; f++) begin
      wr(acp_pkg::OFF_CTRL, f ? 16'h8500 : 16'h8400);
      foreach (ins[j]) begin
        rd(acp_pkg::OFF_RES + {2'b00, ins[j], 2'b00});
        chk("res", f ? {ins[j], 6'h15, 6'h00} : {6'h00, ins[j], 6'h15}, rdv);
      end
    end
    chk("irqs", 16'h0002, 16'(irq_n));
    wr(acp_pkg::OFF_STAT, 16'h0000);
    rd(acp_pkg::OFF_BASE);
    chk("base", 16'h0100, rdv);
    conv(16'h8007, 8'hA1, l7);
    conv(16'h8000, 8'hA1, l0);
    conv(16'h8001, 8'hA1, l1);
    chk("div", 16'h00F0, 16'(l7 - l0));
    chk("rsv", 16'(l0), 16'(l1));
    rd(acp_pkg::OFF_PAIR0);
    chk("pair", 16'h0081, rdv);
    conv(16'h80C0, 8'hA1, l1);
    chk("odd", 16'h0001, {12'h000, chq[$]});
    chk("early", 16'h0001, {15'h0000, irq_busy});
    n = irq_n;
    conv(16'h8000, 8'h21, l1);
    chk("noirq", 16'(n), 16'(irq_n));
    wr(acp_pkg::OFF_CTRL, 16'h0020);
    wr(acp_pkg::OFF_CTRL, 16'h8020);
    wr(acp_pkg::OFF_PAIR2, 16'h0003);
    ext_trig_i <= 32'h0000_0008;
    @(posedge sys_clk_i);
    ext_trig_i <= 32'h0000_0000;
    repeat (250) @(posedge sys_clk_i);
    chk("shared", 16'h0209, {sh_n, 4'h0, sh_chan});
    chk("ded", 16'h0203, {4'h0, ded_seen});
    rd(acp_pkg::OFF_STAT);
    chk("stat", 16'h0011, rdv);
    for (int k = 0; k < 2; k++) begin
      pll_sel_i <= k[0];
      idle_mode_i <= 1'b1;
      wr(acp_pkg::OFF_CTRL, k ? 16'hA000 : 16'h8000);
      wr(acp_pkg::OFF_PAIR0, 16'h0021);
      repeat (20) @(posedge sys_clk_i);
      rd(acp_pkg::OFF_PAIR0);
      chk("halt", 16'h0021, rdv);
      wr(acp_pkg::OFF_PAIR0, 16'h0000);
    end
    conclude();
  end
endmodule
